//--- hw/sra_pkg.sv
package sra_pkg;

	// ==========================================================
	// clock and delay timing
	localparam int unsigned CLK_FREQ_HZ       = 40_000_000;
	localparam int unsigned DELAY_UNIT_S      = 1;
	localparam int unsigned DELAY_UNIT_CYCLES = CLK_FREQ_HZ * DELAY_UNIT_S;

	// ==========================================================
	// widths and ranges
	localparam int unsigned VAL_W   = 16;
	localparam int unsigned DLY_W   = 14;
	localparam int unsigned NUM_SP  = 4;

	localparam logic signed [15:0] THR_MIN   = 16'shF831;
	localparam logic signed [15:0] THR_MAX   = 16'sh270F;
	localparam logic [13:0]        DELAY_MAX = 14'h270F;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFS_THR1    = 8'h00;
	localparam logic [7:0] OFS_THR2    = 8'h04;
	localparam logic [7:0] OFS_THR3    = 8'h08;
	localparam logic [7:0] OFS_THR4    = 8'h0C;
	localparam logic [7:0] OFS_MAKE    = 8'h10;
	localparam logic [7:0] OFS_BREAK   = 8'h14;
	localparam logic [7:0] OFS_CTRL    = 8'h18;
	localparam logic [7:0] OFS_STATUS  = 8'h1C;
	localparam logic [7:0] OFS_READING = 8'h20;

	// ==========================================================
	// field positions
	localparam int unsigned CTRL_BAND_BIT  = 0;
	localparam int unsigned CTRL_PAT_LSB   = 1;
	localparam int unsigned STAT_RELAY_LSB = 0;
	localparam int unsigned STAT_CMP_LSB   = 4;
	localparam int unsigned STAT_BANDM_BIT = 8;
	localparam int unsigned STAT_BANDS_BIT = 9;
	localparam int unsigned STAT_PEND_BIT  = 10;

	// ==========================================================
	// sense patterns, leftmost letter is the first setpoint
	typedef enum logic [1:0]
	{
		SRA_PAT_LLLL = 2'b00,
		SRA_PAT_LHLH = 2'b01,
		SRA_PAT_LHHH = 2'b10,
		SRA_PAT_HHHH = 2'b11
	} sra_pattern_e;

	// ==========================================================
	// reset values of the stored settings
	localparam logic signed [15:0] RST_THR1    = 16'sh0000;
	localparam logic signed [15:0] RST_THR2    = 16'sh0000;
	localparam logic signed [15:0] RST_THR3    = 16'sh0000;
	localparam logic signed [15:0] RST_THR4    = 16'sh0000;
	localparam logic [13:0]        RST_DELAY   = 14'h0000;
	localparam logic               RST_BAND    = 1'b0;
	localparam sra_pattern_e       RST_PATTERN = SRA_PAT_HHHH;

	// AHB transfer type bit that marks NONSEQ or SEQ
	localparam int unsigned HTRANS_ACT_BIT = 1;

endpackage

//--- hw/sra_delay_if.sv
`timescale 1ns/100ps
`default_nettype none

interface sra_delay_if;
	logic        alarm;
	logic [13:0] make_delay;
	logic [13:0] break_delay;
	logic        restart;
	logic        tick;
	logic        relay;
	logic        pending;

	modport ctrl   (output alarm, output make_delay, output break_delay, input relay, input pending);
	modport timer  (input alarm, input make_delay, input break_delay, input tick,
		output restart, output relay, output pending);
	modport ticker (input restart, output tick);
endinterface

`default_nettype wire

//--- hw/sra_second_tick.sv
`timescale 1ns/100ps
`default_nettype none

module sra_second_tick
	import sra_pkg::*;
#(
	parameter int unsigned UNIT_CYCLES = DELAY_UNIT_CYCLES
)
(
	input  wire logic clock_i,
	input  wire logic resetn_i,
	sra_delay_if.ticker dly
);

	localparam int unsigned CW = $clog2(UNIT_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(UNIT_CYCLES - 1);

	logic [CW-1:0] cnt_r;

	// restarted with each new wait so the first second is a whole one
	always_ff @(posedge clock_i)
	begin
		if (!resetn_i || dly.restart || cnt_r == LAST)
			cnt_r <= '0;
		else
			cnt_r <= cnt_r + CW'(1);
	end

	assign dly.tick = !dly.restart && (cnt_r == LAST);

endmodule

`default_nettype wire

//--- hw/sra_delay_timer.sv
`timescale 1ns/100ps
`default_nettype none

module sra_delay_timer
	import sra_pkg::*;
(
	input  wire logic clock_i,
	input  wire logic resetn_i,
	sra_delay_if.timer dly
);

	logic [13:0] secs_r;
	logic        relay_r;
	logic        pending;
	logic [13:0] target;

	assign pending     = dly.alarm != relay_r;
	assign target      = dly.alarm ? dly.make_delay : dly.break_delay;
	assign dly.restart = !pending;
	assign dly.relay   = relay_r;
	assign dly.pending = pending;

	// a condition that reverts drops the wait and starts over
	always_ff @(posedge clock_i)
	begin
		if (!resetn_i || !pending || secs_r >= target)
			secs_r <= '0;
		else if (dly.tick)
			secs_r <= secs_r + 14'h0001;
	end

	always_ff @(posedge clock_i)
	begin
		if (!resetn_i)
			relay_r <= 1'b0;
		else if (pending && secs_r >= target)
			relay_r <= dly.alarm;
	end

endmodule

`default_nettype wire

//--- hw/sra_setpoint_relay.sv
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - all four setpoints are compared on every reading, relay fitted or not.
// - high sense energizes above the setpoint, low sense below it.
// - four sense positions, first to fourth; only LLLL, LhLh, Lhhh, hhhh exist.
// - first relay energizes after alarm persists unbroken for the make delay, 0-9999 s.
// - first relay releases after non-alarm persists unbroken for the break delay, 0-9999 s.
// - third and fourth relays follow their comparisons directly, no delays.
// - band mode applies only with band enabled and second setpoint above first.
// - in band mode second setpoint is upper limit, first setpoint lower limit.
// - band with LhLh: on below first setpoint, held until second setpoint reached.
// - band with hhhh: on above second setpoint, held until first setpoint reached.
// - setpoints span -1999 to 9999; a high-sense setpoint at 9999 or a low-sense setpoint at -1999 never triggers.
module sra_setpoint_relay
	import sra_pkg::*;
#(
	parameter int unsigned SECOND_CYCLES = DELAY_UNIT_CYCLES
)
(
	input  wire logic              clock_i,
	input  wire logic              resetn_i,
	input  wire logic              hsel_i,
	input  wire logic [31:0]       haddr_i,
	input  wire logic [1:0]        htrans_i,
	input  wire logic              hwrite_i,
	input  wire logic [2:0]        hsize_i,
	input  wire logic [31:0]       hwdata_i,
	input  wire logic              hready_i,
	output logic      [31:0]       hrdata_o,
	output logic                   hreadyout_o,
	output logic                   hresp_o,
	input  wire logic [VAL_W-1:0]  reading_i,
	input  wire logic              reading_valid_i,
	output logic      [NUM_SP-1:0] relay_o,
	output logic      [NUM_SP-1:0] indicator_o
);

	// ==========================================================
	// helpers
	function automatic logic signed [15:0] clamp_thr(input logic signed [15:0] v);
		if (v < THR_MIN)
			return THR_MIN;
		else if (v > THR_MAX)
			return THR_MAX;
		else
			return v;
	endfunction

	function automatic logic [13:0] clamp_dly(input logic [15:0] v);
		if (v > {2'b00, DELAY_MAX})
			return DELAY_MAX;
		else
			return v[13:0];
	endfunction

	// bit i high means setpoint i+1 uses high sense
	function automatic logic [3:0] sense_of(input sra_pattern_e p);
		case (p)
			SRA_PAT_LLLL: return 4'h0;
			SRA_PAT_LHLH: return 4'hA;
			SRA_PAT_LHHH: return 4'hE;
			SRA_PAT_HHHH: return 4'hF;
			default:      return 4'hF;
		endcase
	endfunction

	// register select, shared by the read mux and the write decode
	typedef enum logic [3:0]
	{
		SRA_SEL_THR1    = 4'h0,
		SRA_SEL_THR2    = 4'h1,
		SRA_SEL_THR3    = 4'h2,
		SRA_SEL_THR4    = 4'h3,
		SRA_SEL_MAKE    = 4'h4,
		SRA_SEL_BREAK   = 4'h5,
		SRA_SEL_CTRL    = 4'h6,
		SRA_SEL_STATUS  = 4'h7,
		SRA_SEL_READING = 4'h8,
		SRA_SEL_NONE    = 4'hF
	} sra_sel_e;

	// unaligned or unmapped offsets fall to none: read as zero, writes dropped
	function automatic sra_sel_e sel_of(input logic [7:0] a);
		case (a)
			OFS_THR1:    return SRA_SEL_THR1;
			OFS_THR2:    return SRA_SEL_THR2;
			OFS_THR3:    return SRA_SEL_THR3;
			OFS_THR4:    return SRA_SEL_THR4;
			OFS_MAKE:    return SRA_SEL_MAKE;
			OFS_BREAK:   return SRA_SEL_BREAK;
			OFS_CTRL:    return SRA_SEL_CTRL;
			OFS_STATUS:  return SRA_SEL_STATUS;
			OFS_READING: return SRA_SEL_READING;
			default:     return SRA_SEL_NONE;
		endcase
	endfunction

	// ==========================================================
	// stored settings and state
	logic signed [15:0] thr_r [NUM_SP];
	logic [13:0]        make_r;
	logic [13:0]        break_r;
	logic               band_en_r;
	sra_pattern_e       pattern_r;
	logic signed [15:0] reading_r;
	logic [NUM_SP-1:0]  cmp_r;
	logic               band_r;

	logic               wr_pend_r;
	logic [7:0]         wr_addr_r;
	logic [31:0]        rdata_r;

	logic [3:0]         sense;
	logic               band_mode;
	logic signed [15:0] rd_now;
	logic               addr_phase;
	logic [31:0]        status;
	logic [31:0]        ctrl_word;

	sra_delay_if dly ();

	assign sense     = sense_of(pattern_r);
	assign band_mode = band_en_r && (thr_r[1] > thr_r[0]);
	assign rd_now    = clamp_thr($signed(reading_i));

	// ==========================================================
	// AHB-Lite slave, zero wait states, always OKAY
	assign addr_phase  = hsel_i && htrans_i[HTRANS_ACT_BIT] && hready_i;
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	assign hrdata_o    = rdata_r;

	always_ff @(posedge clock_i)
	begin
		if (!resetn_i)
		begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end
		else if (hready_i)
		begin
			wr_pend_r <= addr_phase && hwrite_i;
			wr_addr_r <= haddr_i[7:0];
		end
	end

	// fields placed by name so a layout change stays in the package
	always_comb
	begin
		status                           = 32'h00000000;
		status[STAT_RELAY_LSB +: NUM_SP] = relay_o;
		status[STAT_CMP_LSB +: NUM_SP]   = cmp_r;
		status[STAT_BANDM_BIT]           = band_mode;
		status[STAT_BANDS_BIT]           = band_r;
		status[STAT_PEND_BIT]            = dly.pending;
	end

	always_comb
	begin
		ctrl_word                        = 32'h00000000;
		ctrl_word[CTRL_BAND_BIT]         = band_en_r;
		ctrl_word[CTRL_PAT_LSB +: 2]     = pattern_r;
	end

	// read data is captured in the address phase and stands through the data phase
	always_ff @(posedge clock_i)
	begin
		if (!resetn_i)
			rdata_r <= 32'h00000000;
		else if (addr_phase && !hwrite_i)
		begin
			case (sel_of(haddr_i[7:0]))
				SRA_SEL_THR1:    rdata_r <= 32'(thr_r[0]);
				SRA_SEL_THR2:    rdata_r <= 32'(thr_r[1]);
				SRA_SEL_THR3:    rdata_r <= 32'(thr_r[2]);
				SRA_SEL_THR4:    rdata_r <= 32'(thr_r[3]);
				SRA_SEL_MAKE:    rdata_r <= {18'h00000, make_r};
				SRA_SEL_BREAK:   rdata_r <= {18'h00000, break_r};
				SRA_SEL_CTRL:    rdata_r <= ctrl_word;
				SRA_SEL_STATUS:  rdata_r <= status;
				SRA_SEL_READING: rdata_r <= 32'(reading_r);
				default:         rdata_r <= 32'h00000000;
			endcase
		end
	end

	// writes land in the data phase; out-of-range values are pulled to the limits
	always_ff @(posedge clock_i)
	begin
		if (!resetn_i)
		begin
			thr_r[0]  <= RST_THR1;
			thr_r[1]  <= RST_THR2;
			thr_r[2]  <= RST_THR3;
			thr_r[3]  <= RST_THR4;
			make_r    <= RST_DELAY;
			break_r   <= RST_DELAY;
			band_en_r <= RST_BAND;
			pattern_r <= RST_PATTERN;
		end
		else if (wr_pend_r)
		begin
			case (sel_of(wr_addr_r))
				SRA_SEL_THR1:  thr_r[0] <= clamp_thr($signed(hwdata_i[15:0]));
				SRA_SEL_THR2:  thr_r[1] <= clamp_thr($signed(hwdata_i[15:0]));
				SRA_SEL_THR3:  thr_r[2] <= clamp_thr($signed(hwdata_i[15:0]));
				SRA_SEL_THR4:  thr_r[3] <= clamp_thr($signed(hwdata_i[15:0]));
				SRA_SEL_MAKE:  make_r   <= clamp_dly(hwdata_i[15:0]);
				SRA_SEL_BREAK: break_r  <= clamp_dly(hwdata_i[15:0]);
				SRA_SEL_CTRL:
				begin
					band_en_r <= hwdata_i[CTRL_BAND_BIT];
					pattern_r <= sra_pattern_e'(hwdata_i[CTRL_PAT_LSB +: 2]);
				end
				default:   ;
			endcase
		end
	end

	// ==========================================================
	// comparison on each conversion
	always_ff @(posedge clock_i)
	begin
		if (!resetn_i)
			reading_r <= 16'sh0000;
		else if (reading_valid_i)
			reading_r <= rd_now;
	end

	// strict compare: a reading pinned at the range limit never passes an extreme setpoint
	always_ff @(posedge clock_i)
	begin
		if (!resetn_i)
			cmp_r <= '0;
		else if (reading_valid_i)
		begin
			for (int i = 0; i < NUM_SP; i++)
			begin
				if (sense[i])
					cmp_r[i] <= rd_now > thr_r[i];
				else
					cmp_r[i] <= rd_now < thr_r[i];
			end
		end
	end

	// ==========================================================
	// pump fill/empty band on the first relay
	always_ff @(posedge clock_i)
	begin
		if (!resetn_i || !band_mode)
			band_r <= 1'b0;
		else if (reading_valid_i)
		begin
			if (!sense[0])
			begin
				if (rd_now < thr_r[0])
					band_r <= 1'b1;
				else if (rd_now >= thr_r[1])
					band_r <= 1'b0;
			end
			else
			begin
				if (rd_now > thr_r[1])
					band_r <= 1'b1;
				else if (rd_now <= thr_r[0])
					band_r <= 1'b0;
			end
		end
	end

	assign dly.alarm       = band_mode ? band_r : cmp_r[0];
	assign dly.make_delay  = make_r;
	assign dly.break_delay = break_r;

	sra_second_tick #(
		.UNIT_CYCLES (SECOND_CYCLES)
	) u_tick (
		.clock_i  (clock_i),
		.resetn_i (resetn_i),
		.dly      (dly)
	);

	sra_delay_timer u_timer (
		.clock_i  (clock_i),
		.resetn_i (resetn_i),
		.dly      (dly)
	);

	// ==========================================================
	// outputs; lamps mirror the contacts so unfitted relays still show
	assign relay_o     = {cmp_r[3:1], dly.relay};
	assign indicator_o = relay_o;

endmodule

`default_nettype wire

//--- sim/sra_setpoint_relay_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module sra_setpoint_relay_assertions
	import sra_pkg::*;
#(parameter int unsigned SECOND_CYCLES = DELAY_UNIT_CYCLES)
(
	input wire logic        clock_i,
	input wire logic        resetn_i,
	input wire logic        hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0]  htrans_i,
	input wire logic        hwrite_i,
	input wire logic [2:0]  hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic        hready_i,
	input wire logic [31:0] hrdata_o,
	input wire logic        hreadyout_o,
	input wire logic        hresp_o,
	input wire logic [15:0] reading_i,
	input wire logic        reading_valid_i,
	input wire logic [3:0]  relay_o,
	input wire logic [3:0]  indicator_o
);
	// ====
	// read address phase taken
	wire logic rd_take = hsel_i && htrans_i[1] && hready_i && !hwrite_i;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	// ====
	// properties
	a_ind_follow: assert property (indicator_o == relay_o)
		else $error("indicators differ from relays");
	a_far_direct: assert property ($changed(relay_o[3:2]) |-> $past(reading_valid_i))
		else $error("third or fourth relay moved without a reading");
	a_second_direct: assert property (!$past(reading_valid_i) |-> $stable(relay_o[1]))
		else $error("second relay moved without a reading");
	a_reset_clear: assert property ($rose(resetn_i) |-> relay_o == 4'h0 && hrdata_o == 32'h0)
		else $error("outputs not clear after reset");
	a_bus_okay: assert property (hreadyout_o && !hresp_o)
		else $error("slave stalled or answered an error");
	a_unmapped_zero: assert property (rd_take && haddr_i[7:0] > OFS_READING |=> hrdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_status_relay: assert property (rd_take && haddr_i[7:0] == OFS_STATUS |=> hrdata_o[3:0] == $past(relay_o))
		else $error("status relay field differs from relays");
	a_rdata_hold: assert property (!rd_take |=> $stable(hrdata_o))
		else $error("read data moved without a read");

	c_first_on: cover property ($rose(relay_o[0]));
	c_all_on: cover property (relay_o == 4'hF);
	c_status_read: cover property (rd_take && haddr_i[7:0] == OFS_STATUS);
endmodule
bind sra_setpoint_relay sra_setpoint_relay_assertions #(.SECOND_CYCLES(SECOND_CYCLES)) u_chk (.clock_i, .resetn_i,
	.hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o,
	.reading_i, .reading_valid_i, .relay_o, .indicator_o);
`default_nettype wire

//--- sim/sra_relay_contacts.sv
`timescale 1ns/100ps
`default_nettype none
module sra_relay_contacts
(
	input  wire logic [3:0] relay_i,
	input  wire logic [3:0] indicator_i,
	output logic      [3:0] closed_o,
	output logic      [3:0] lit_o
);
	// contacts close on an energized coil; bounce not modelled
	assign closed_o = relay_i;
	assign lit_o    = indicator_i;
endmodule
`default_nettype wire

//--- sim/sra_setpoint_relay_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sra_setpoint_relay_tb
	import sra_pkg::*;
;
	// short second keeps delay runs brief
	localparam int unsigned SEC = 10;
	logic        clock_i, resetn_i, hsel_i, hwrite_i, reading_valid_i;
	logic [1:0]  htrans_i;
	logic [31:0] haddr_i, hwdata_i, rd;
	logic [15:0] reading_i;
	logic [3:0]  e;
	wire logic [31:0] hrdata_o;
	wire logic        hreadyout_o, hresp_o;
	wire logic [3:0]  relay_o, indicator_o, closed, lit;
	int          miscompares = 0;
	int          n_tests = 0;
	logic [3:0]  sense [4] = '{4'h0, 4'hA, 4'hE, 4'hF};
	logic [15:0] vals [3] = '{16'd100, 16'd99, 16'd101};

	sra_setpoint_relay #(.SECOND_CYCLES(SEC)) DUT (.clock_i(clock_i), .resetn_i(resetn_i), .hsel_i(hsel_i),
		.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
		.hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
		.reading_i(reading_i), .reading_valid_i(reading_valid_i), .relay_o(relay_o), .indicator_o(indicator_o));
	sra_relay_contacts PART (.relay_i(relay_o), .indicator_i(indicator_o), .closed_o(closed), .lit_o(lit));

	initial
	begin
		clock_i = 1'b0;
		forever #12.5 clock_i = ~clock_i;
	end

	// ====
	// tasks
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_tests++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		haddr_i <= {24'h0, a};
		htrans_i <= 2'b10;
		hwrite_i <= wr;
		do @(posedge clock_i); while (hreadyout_o !== 1'b1);
		htrans_i <= 2'b00;
		hwdata_i <= d;
		do @(posedge clock_i); while (hreadyout_o !== 1'b1);
		rd = hrdata_o;
	endtask
	task automatic thr_all(input logic [31:0] v);
		for (int i = 0; i < 4; i++)
			bus(1'b1, OFS_THR1 + 8'(4 * i), v);
	endtask
	task automatic feed(input logic [15:0] v);
		@(posedge clock_i);
		reading_i <= v;
		reading_valid_i <= 1'b1;
		@(posedge clock_i);
		reading_valid_i <= 1'b0;
		repeat (4) @(posedge clock_i);
	endtask
	task automatic bstep(input logic [15:0] v, input logic exp);
		feed(v);
		check(closed[0], exp, "band relay");
	endtask
	task automatic await0(input logic exp, input int lo, input int hi);
		int n = 0;
		while (relay_o[0] !== exp && n < hi)
		begin
			@(posedge clock_i);
			n++;
		end
		check(n >= lo && n < hi, 1, "first relay delay");
	endtask

	initial
	begin
		#(25 * 20000);
		miscompares++;
		summarize();
	end

	// ====
	// tests
	initial
	begin
		resetn_i = 1'b0;
		hsel_i = 1'b1;
		hwrite_i = 1'b0;
		htrans_i = 2'b00;
		haddr_i = 32'h0;
		hwdata_i = 32'h0;
		reading_i = 16'h0;
		reading_valid_i = 1'b0;
		repeat (6) @(posedge clock_i);
		resetn_i <= 1'b1;
		bus(1'b0, OFS_CTRL, 32'h0);
		check(rd, 32'h6, "ctrl reset");
		bus(1'b0, 8'h40, 32'h0);
		check(rd, 32'h0, "unmapped");
		$display("reset test done");
		thr_all(32'd100);
		for (int p = 0; p < 4; p++)
		begin
			bus(1'b1, OFS_CTRL, {29'h0, 2'(p), 1'b0});
			for (int k = 0; k < 3; k++)
			begin
				feed(vals[k]);
				e = (vals[k] > 100) ? sense[p] : (vals[k] < 100) ? ~sense[p] : 4'h0;
				check(closed, e, "relays");
				check(lit, e, "indicators");
			end
		end
		bus(1'b0, OFS_STATUS, 32'h0);
		check(rd[3:0], 4'hF, "status relays");
		$display("sense test done");
		thr_all(32'h4E20);
		bus(1'b0, OFS_THR4, 32'h0);
		check(rd, 32'h270F, "upper clamp");
		feed(16'h4E20);
		check(closed, 4'h0, "top extreme");
		thr_all(32'h8000);
		bus(1'b0, OFS_THR1, 32'h0);
		check(rd, 32'hFFFFF831, "lower clamp");
		bus(1'b1, OFS_CTRL, 32'h0);
		feed(16'h8000);
		check(closed, 4'h0, "bottom extreme");
		$display("extreme test done");
		bus(1'b1, OFS_CTRL, 32'h6);
		thr_all(32'h0);
		bus(1'b1, OFS_MAKE, 32'd2);
		bus(1'b1, OFS_BREAK, 32'd1);
		feed(16'd10);
		feed(-16'sd5);
		feed(16'd10);
		await0(1'b1, 10, 30);
		feed(-16'sd5);
		await0(1'b0, 2, 20);
		bus(1'b1, OFS_MAKE, 32'd0);
		bus(1'b1, OFS_BREAK, 32'd0);
		$display("delay test done");
		bus(1'b1, OFS_THR2, 32'd100);
		bus(1'b1, OFS_CTRL, 32'h7);
		bstep(16'd50, 1'b0);
		bstep(16'd101, 1'b1);
		bstep(16'd50, 1'b1);
		bstep(16'd0, 1'b0);
		bstep(16'd50, 1'b0);
		bus(1'b1, OFS_CTRL, 32'h3);
		bstep(-16'sd1, 1'b1);
		bstep(16'd50, 1'b1);
		bstep(16'd100, 1'b0);
		bus(1'b1, OFS_THR2, -32'sd10);
		bus(1'b1, OFS_CTRL, 32'h7);
		bstep(16'd50, 1'b1);
		bstep(16'd0, 1'b0);
		$display("band test done");
		summarize();
	end
endmodule
`default_nettype wire
